// ==== shared/smc_pkg.sv ====
/*
 * constants, register map and state codes of the standby mode controller.
 * assumes a 100 MHz main oscillator clock and a word-aligned avalon-mm bus.
 */
// Summary of operation
// - mask writes ignored alongside trigger set
// - mode select bits used only with trigger
// - settle count starts after oscillator runs
// - settle select resets to sixteen-bit wait
// - halt entered, pending request releases it
// - pending unmasked request releases light idle
// - masked source does not release light idle
// - pending unmasked request releases deep idle
// - masked source does not release deep idle
package smc_pkg;
    // register byte addresses
    localparam logic [3:0] addr_power_save_control = 4'h0;
    localparam logic [3:0] addr_power_save_mode_select = 4'h4;
    localparam logic [3:0] addr_osc_settle_time_select = 4'h8;
    localparam logic [3:0] addr_status = 4'hc;
    // power_save_control fields
    localparam int bit_standby_trigger = 0;
    localparam int bit_maskable_irq_wake_mask = 1;
    localparam int bit_first_nmi_wake_mask = 2;
    localparam int bit_second_nmi_wake_mask = 3;
    // power_save_mode_select field codes
    localparam logic [1:0] mode_light_idle = 2'h0;
    localparam logic [1:0] mode_deep_idle = 2'h1;
    // reset values
    localparam logic [2:0] osc_settle_reset = 3'h6;
    localparam logic [1:0] mode_select_reset = 2'h0;
    localparam logic [2:0] wake_mask_reset = 3'h0;
    // settle count: 2^(settle_log2_at_6 - 6 + select) clocks
    localparam int settle_log2_at_6 = 16;
    localparam int settle_sel_offset = 6;
    localparam int settle_cnt_w = 17;
    typedef enum logic [6:0] {
        smc_run = 7'h01,
        smc_halt = 7'h02,
        smc_light_idle = 7'h04,
        smc_deep_idle = 7'h08,
        smc_stop = 7'h10,
        smc_osc_wait = 7'h20,
        smc_settle = 7'h40
    } smc_state_type;
endpackage

// ==== hw/smc_top.sv ====
/*
 * standby mode controller: halt, light idle, deep idle and stop modes with
 * wake masks and oscillator settle timing, registers over avalon-mm.
 * assumes request inputs synchronous to clk and the cpu reports halt.
 */
// Our own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module smc_top #(
    parameter int settle_log2 = smc_pkg::settle_log2_at_6
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // cpu and interrupt side
    input wire logic halt_exec,
    input wire logic irq_pending,
    input wire logic first_nmi_pending,
    input wire logic second_nmi_pending,
    input wire logic osc_started,
    // clock control
    output logic cpu_clk_stop,
    output logic periph_clk_stop,
    output logic osc_stop
);
    smc_pkg::smc_state_type state_q, state_d;
    logic trig_q, trig_d;
    logic [2:0] mask_q, mask_d;
    logic [1:0] msel_q, msel_d;
    logic [2:0] osc_settle_time_select_q, osc_settle_time_select_d;
    logic [smc_pkg::settle_cnt_w-1:0] cnt_q, cnt_d;
    logic wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    logic cpu_q, cpu_d, per_q, per_d, osc_q, osc_d;
    logic acc, wr, wake_masked, wake_any;
    logic [smc_pkg::settle_cnt_w-1:0] settle_len, settle_last;

    assign acc = (avs_read | avs_write) & ~wait_q;
    assign wr = acc & avs_write & avs_byteenable[0];
    assign wake_any = irq_pending | first_nmi_pending | second_nmi_pending;
    assign wake_masked = (irq_pending & ~mask_q[0]) | (first_nmi_pending & ~mask_q[1]) |
        (second_nmi_pending & ~mask_q[2]);
    assign settle_len = smc_pkg::settle_cnt_w'((settle_log2 - smc_pkg::settle_sel_offset) + 32'(osc_settle_time_select_q));
    assign settle_last = (smc_pkg::settle_cnt_w'(1) << settle_len) - 1'b1;

    always_comb begin
        state_d = state_q;
        trig_d = trig_q;
        mask_d = mask_q;
        msel_d = msel_q;
        osc_settle_time_select_d = osc_settle_time_select_q;
        cnt_d = cnt_q;
        wait_d = 1'b1;
        rdata_d = rdata_q;
        if ((avs_read | avs_write) & wait_q) begin
            wait_d = 1'b0;
            rdata_d = 32'h0;
            if (avs_address == smc_pkg::addr_power_save_control) begin
                rdata_d = {28'h0, mask_q[2], mask_q[1], mask_q[0], trig_q};
            end else if (avs_address == smc_pkg::addr_power_save_mode_select) begin
                rdata_d = {30'h0, msel_q};
            end else if (avs_address == smc_pkg::addr_osc_settle_time_select) begin
                rdata_d = {29'h0, osc_settle_time_select_q};
            end else if (avs_address == smc_pkg::addr_status) begin
                rdata_d = {25'h0, state_q};
            end
        end
        if (wr) begin
            if (avs_address == smc_pkg::addr_power_save_control) begin
                if (avs_writedata[smc_pkg::bit_standby_trigger] && state_q == smc_pkg::smc_run) begin
                    trig_d = 1'b1; // mask bits ignored in this write
                end else if (!avs_writedata[smc_pkg::bit_standby_trigger]) begin
                    mask_d = {avs_writedata[smc_pkg::bit_second_nmi_wake_mask],
                        avs_writedata[smc_pkg::bit_first_nmi_wake_mask],
                        avs_writedata[smc_pkg::bit_maskable_irq_wake_mask]};
                end
            end else if (avs_address == smc_pkg::addr_power_save_mode_select) begin
                msel_d = avs_writedata[1:0];
            end else if (avs_address == smc_pkg::addr_osc_settle_time_select) begin
                osc_settle_time_select_d = avs_writedata[2:0];
            end
        end
        case (state_q)
            smc_pkg::smc_run: begin
                if (trig_q) begin
                    // mode bits looked at only here
                    if (msel_q == smc_pkg::mode_light_idle) begin
                        state_d = smc_pkg::smc_light_idle;
                    end else if (msel_q == smc_pkg::mode_deep_idle) begin
                        state_d = smc_pkg::smc_deep_idle;
                    end else begin
                        state_d = smc_pkg::smc_stop;
                    end
                end else if (halt_exec) begin
                    state_d = smc_pkg::smc_halt; // entered even if pending
                end
            end
            smc_pkg::smc_halt: begin
                if (wake_any) begin
                    state_d = smc_pkg::smc_run; // masks do not apply
                end
            end
            smc_pkg::smc_light_idle, smc_pkg::smc_deep_idle: begin
                if (wake_masked) begin
                    state_d = smc_pkg::smc_run;
                    trig_d = 1'b0;
                end
            end
            smc_pkg::smc_stop: begin
                if (wake_masked) begin
                    state_d = smc_pkg::smc_osc_wait;
                    trig_d = 1'b0;
                end
            end
            smc_pkg::smc_osc_wait: begin
                cnt_d = '0;
                if (osc_started) begin
                    state_d = smc_pkg::smc_settle; // count starts after startup
                end
            end
            smc_pkg::smc_settle: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == settle_last) begin
                    state_d = smc_pkg::smc_run;
                end
            end
            default: begin
                state_d = smc_pkg::smc_osc_wait;
            end
        endcase
        cpu_d = state_d != smc_pkg::smc_run;
        per_d = state_d == smc_pkg::smc_light_idle || state_d == smc_pkg::smc_deep_idle ||
            state_d == smc_pkg::smc_stop || state_d == smc_pkg::smc_osc_wait ||
            state_d == smc_pkg::smc_settle;
        osc_d = state_d == smc_pkg::smc_stop;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= smc_pkg::smc_osc_wait; // settle wait after reset
            trig_q <= 1'b0;
            mask_q <= smc_pkg::wake_mask_reset;
            msel_q <= smc_pkg::mode_select_reset;
            osc_settle_time_select_q <= smc_pkg::osc_settle_reset;
            cnt_q <= '0;
            wait_q <= 1'b1;
            rdata_q <= 32'h0;
            cpu_q <= 1'b1;
            per_q <= 1'b1;
            osc_q <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
            trig_q <= trig_d;
            mask_q <= mask_d;
            msel_q <= msel_d;
            osc_settle_time_select_q <= osc_settle_time_select_d;
            cnt_q <= cnt_d;
            wait_q <= wait_d;
            rdata_q <= rdata_d;
            cpu_q <= cpu_d;
            per_q <= per_d;
            osc_q <= osc_d;
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign cpu_clk_stop = cpu_q;
    assign periph_clk_stop = per_q;
    assign osc_stop = osc_q;

    sequence s_enter_idle;
        ce && state_q == smc_pkg::smc_run && trig_q && msel_q == smc_pkg::mode_light_idle;
    endsequence
    sequence s_idle_wake;
        ce && (state_q == smc_pkg::smc_light_idle || state_q == smc_pkg::smc_deep_idle) && wake_masked;
    endsequence

    property p_mask_ignored;
        @(posedge clk) disable iff (rst)
        ce && wr && avs_address == smc_pkg::addr_power_save_control &&
        avs_writedata[smc_pkg::bit_standby_trigger] |=> $stable(mask_q);
    endproperty
    a_mask_ignored: assert property (p_mask_ignored) else $error("mask changed with trigger");

    property p_no_mode_without_trig;
        @(posedge clk) disable iff (rst)
        ce && state_q == smc_pkg::smc_run && !trig_q |=> state_q != smc_pkg::smc_stop &&
            state_q != smc_pkg::smc_light_idle && state_q != smc_pkg::smc_deep_idle;
    endproperty
    a_no_mode_without_trig: assert property (p_no_mode_without_trig) else $error("mode without trigger");

    property p_settle_after_osc;
        @(posedge clk) disable iff (rst)
        state_q == smc_pkg::smc_osc_wait && !osc_started |=> state_q == smc_pkg::smc_osc_wait;
    endproperty
    a_settle_after_osc: assert property (p_settle_after_osc) else $error("settle before oscillator");

    property p_settle_reset;
        @(posedge clk) rst ##1 !rst
            |-> osc_settle_time_select_q == smc_pkg::osc_settle_reset && state_q == smc_pkg::smc_osc_wait;
    endproperty
    a_settle_reset: assert property (p_settle_reset) else $error("bad settle reset");

    property p_halt_release;
        @(posedge clk) disable iff (rst)
        ce && state_q == smc_pkg::smc_run && !trig_q && halt_exec ##1 ce && wake_any
            |=> state_q == smc_pkg::smc_run;
    endproperty
    a_halt_release: assert property (p_halt_release) else $error("halt not released");

    property p_idle_enter;
        @(posedge clk) disable iff (rst)
        s_enter_idle |=> state_q == smc_pkg::smc_light_idle;
    endproperty
    a_idle_enter: assert property (p_idle_enter) else $error("light idle not entered");

    property p_idle_wake;
        @(posedge clk) disable iff (rst)
        s_idle_wake |=> state_q == smc_pkg::smc_run && !trig_q && !cpu_clk_stop;
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("idle not released");

    property p_masked_hold;
        @(posedge clk) disable iff (rst)
        ce && (state_q == smc_pkg::smc_light_idle || state_q == smc_pkg::smc_deep_idle) && !wake_masked
            |=> $stable(state_q);
    endproperty
    a_masked_hold: assert property (p_masked_hold) else $error("masked source released idle");

    property p_clock_held;
        @(posedge clk) disable iff (rst)
        ce && state_q == smc_pkg::smc_settle && cnt_q != settle_last
            |=> state_q == smc_pkg::smc_settle && cpu_clk_stop;
    endproperty
    a_clock_held: assert property (p_clock_held) else $error("core clock early");
endmodule

// ==== sim/testbench.sv ====
/*
 * self-checking bench of the standby mode controller: avalon-mm tasks,
 * mode entry and release, wake masks, halt and stop settle timing.
 * assumes smc_pkg and smc_top compiled first; ce is held high except for 300 cycles of the last test.
 */
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic [31:0] q;
    logic avs_waitrequest;
    logic halt_exec = 1'b0;
    logic irq_pending = 1'b0;
    logic first_nmi_pending = 1'b0;
    logic second_nmi_pending = 1'b0;
    logic osc_started = 1'b0;
    logic cpu_clk_stop;
    logic periph_clk_stop;
    logic osc_stop;
    int fails = 0;
    int checked = 0;
    int n;
    int m;

    always #5 clk = ~clk;

    smc_top #(.settle_log2(8)) i_smc_top (
        .clk(clk), .rst(rst), .ce(ce),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .halt_exec(halt_exec), .irq_pending(irq_pending), .first_nmi_pending(first_nmi_pending),
        .second_nmi_pending(second_nmi_pending), .osc_started(osc_started),
        .cpu_clk_stop(cpu_clk_stop), .periph_clk_stop(periph_clk_stop), .osc_stop(osc_stop)
    );

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one bus cycle, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 20);
        if (avs_waitrequest !== 1'b0) begin
            fails++;
            $display("ERROR t=%0t bus timeout got=%h exp=%h", $time, 1, 0);
            tally_and_finish();
        end else begin
            q = avs_readdata;
            avs_read <= 1'b0;
            avs_write <= 1'b0;
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask

    // counts cycles until the core clock runs again
    task automatic wait_run(output int c);
        c = 0;
        do begin
            @(negedge clk);
            c++;
        end while (cpu_clk_stop !== 1'b0 && c < 1000);
        if (cpu_clk_stop !== 1'b0) begin
            fails++;
            $display("ERROR t=%0t run timeout got=%h exp=%h", $time, 1, 0);
            tally_and_finish();
        end
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rdchk(smc_pkg::addr_osc_settle_time_select, 32'h6);
        avs_byteenable <= 4'he;
        wr(smc_pkg::addr_osc_settle_time_select, 32'h3);
        avs_byteenable <= 4'hf;
        rdchk(smc_pkg::addr_osc_settle_time_select, 32'h6);
        repeat (20) @(posedge clk);
        rdchk(smc_pkg::addr_status, 32'h20);
        osc_started <= 1'b1;
        wait_run(n);
        chk(n >= 256 && n <= 262, 1);
        rdchk(smc_pkg::addr_status, 32'h1);
        $display("test reset settle done");

        wr(smc_pkg::addr_power_save_mode_select, 32'h1);
        rdchk(smc_pkg::addr_status, 32'h1);
        wr(smc_pkg::addr_power_save_mode_select, 32'h0);
        wr(smc_pkg::addr_power_save_control, 32'hf);
        rdchk(smc_pkg::addr_power_save_control, 32'h1);
        rdchk(smc_pkg::addr_status, 32'h4);
        chk({cpu_clk_stop, periph_clk_stop, osc_stop}, 32'h6);
        irq_pending <= 1'b1;
        rdchk(smc_pkg::addr_status, 32'h1);
        rdchk(smc_pkg::addr_power_save_control, 32'h0);
        wr(smc_pkg::addr_power_save_control, 32'h1);
        @(posedge clk);
        rdchk(smc_pkg::addr_power_save_control, 32'h0);
        wr(smc_pkg::addr_power_save_mode_select, 32'h1);
        wr(smc_pkg::addr_power_save_control, 32'h1);
        @(posedge clk);
        rdchk(smc_pkg::addr_status, 32'h1);
        irq_pending <= 1'b0;
        $display("test idle entry done");

        for (m = 0; m < 2; m++) begin
            wr(smc_pkg::addr_power_save_mode_select, m);
            irq_pending <= 1'b1;
            wr(smc_pkg::addr_power_save_control, 32'h2);
            rdchk(smc_pkg::addr_power_save_control, 32'h2);
            wr(smc_pkg::addr_power_save_control, 32'h1);
            repeat (5) @(posedge clk);
            rdchk(smc_pkg::addr_status, (m == 1) ? 32'h8 : 32'h4);
            first_nmi_pending <= 1'b1;
            rdchk(smc_pkg::addr_status, 32'h1);
            irq_pending <= 1'b0;
            first_nmi_pending <= 1'b0;
        end
        $display("test idle masks done");

        @(posedge clk);
        halt_exec <= 1'b1;
        @(posedge clk);
        halt_exec <= 1'b0;
        @(negedge clk);
        chk(cpu_clk_stop, 1'b1);
        rdchk(smc_pkg::addr_status, 32'h2);
        second_nmi_pending <= 1'b1;
        rdchk(smc_pkg::addr_status, 32'h1);
        second_nmi_pending <= 1'b0;
        irq_pending <= 1'b1;
        @(posedge clk);
        halt_exec <= 1'b1;
        @(posedge clk);
        halt_exec <= 1'b0;
        @(negedge clk);
        chk(cpu_clk_stop, 1'b1);
        @(negedge clk);
        chk(cpu_clk_stop, 1'b0);
        @(posedge clk);
        irq_pending <= 1'b0;
        repeat (5) @(posedge clk); // no new halt for five cycles
        $display("test halt done");

        wr(smc_pkg::addr_power_save_control, 32'h0);
        for (m = 2; m < 4; m++) begin
            wr(smc_pkg::addr_osc_settle_time_select, m - 2);
            wr(smc_pkg::addr_power_save_mode_select, m);
            wr(smc_pkg::addr_power_save_control, 32'h1);
            rdchk(smc_pkg::addr_status, 32'h10);
            chk(osc_stop, 1'b1);
            osc_started <= 1'b0;
            @(posedge clk);
            irq_pending <= 1'b1;
            repeat (20) @(posedge clk);
            rdchk(smc_pkg::addr_status, 32'h20);
            chk(cpu_clk_stop, 1'b1);
            osc_started <= 1'b1;
            wait_run(n);
            chk(n >= (4 << (m - 2)) && n <= (4 << (m - 2)) + 6, 1);
            @(posedge clk);
            irq_pending <= 1'b0;
            rdchk(smc_pkg::addr_power_save_control, 32'h0);
        end
        $display("test stop done");

        rst <= 1'b1;
        osc_started <= 1'b0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rdchk(smc_pkg::addr_osc_settle_time_select, 32'h6);
        rdchk(smc_pkg::addr_status, 32'h20);
        ce <= 1'b0;
        osc_started <= 1'b1;
        repeat (300) @(posedge clk);
        chk(cpu_clk_stop, 1'b1);
        ce <= 1'b1;
        wait_run(n);
        chk(n >= 256 && n <= 262, 1);
        $display("test mid-run reset done");
        tally_and_finish();
    end
endmodule
